// [design/adc_serial_defs.svh]
`ifndef ADC_SERIAL_DEFS_SVH
`define ADC_SERIAL_DEFS_SVH

// Widths.
`define RESULT_BITS       16
`define CFG_BITS          8
`define BIT_CNT_W         5
`define CFG_CNT_W         4
`define DIV_W             4
`define SETTINGS_W        8

// Timing of the internally generated serial result clock.
`define SYS_CLK_PERIOD_NS 25
`define SERIAL_RESULT_CLOCK_HALF_NS     100
`define SERIAL_RESULT_CLOCK_HALF_CYC    ((`SERIAL_RESULT_CLOCK_HALF_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

// Register byte offsets on the Avalon-MM slave.
`define ADDR_W            5
`define REG_CTRL          5'h00
`define REG_STATUS        5'h04
`define REG_IRQ_STATUS    5'h08
`define REG_IRQ_MASK      5'h0C
`define REG_CONFIG        5'h10

// Reset values.
`define CTRL_RESET        6'h00
`define IRQ_RESET         3'h0
`define CFG_RESET         8'h00

`endif

// [design/adc_serial_pkg.sv]
package adc_serial_pkg;

  // Control register, bit 0 upward: serial, slave, invert, polarity, rdc, coding.
  typedef struct packed {
    logic output_coding_select;
    logic read_during_convert_select;
    logic frame_polarity_select;
    logic clock_edge_invert;
    logic clock_source_select;
    logic port_type_select;
  } ctrl_s;

  // Sticky event bits, bit 0 upward: overrun, frame done, config word done.
  typedef struct packed {
    logic cfg_done;
    logic frame_done;
    logic overrun;
  } irq_s;

  // Shared pins, bit 0 upward carry parallel data bits 9 to 13.
  typedef struct packed {
    logic config_serial_in;
    logic config_source_select;
    logic read_overrun_flag;
    logic frame_marker;
    logic serial_result_clock;
  } shared_pins_s;

  typedef enum logic [2:0] {
    SH_IDLE   = 3'b001,
    SH_LOADED = 3'b010,
    SH_SHIFT  = 3'b100
  } shift_state_e;

endpackage

// [design/adc_serial_port.sv]
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`include "adc_serial_defs.svh"
module adc_serial_port (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        srst_i,
  // Avalon-MM slave
  input  wire logic [`ADDR_W-1:0]          avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  input  wire logic [31:0]                 avs_writedata_i,
  output logic      [31:0]                 avs_readdata_o,
  output logic                             avs_waitrequest_o,
  // Conversion core
  input  wire logic                        conv_start_i,
  input  wire logic                        conv_done_i,
  input  wire logic [`RESULT_BITS-1:0]     conv_result_i,
  input  wire logic [`SETTINGS_W-1:0]      hw_settings_i,
  output logic      [`SETTINGS_W-1:0]      active_settings_o,
  // Shared pins
  input  wire adc_serial_pkg::shared_pins_s shared_pin_i,
  output adc_serial_pkg::shared_pins_s      shared_pin_o,
  output adc_serial_pkg::shared_pins_s      shared_pin_oe_o,
  // Dedicated serial pins
  output logic                             serial_result_out_o,
  input  wire logic                        config_serial_clock_i,
  input  wire logic                        config_port_select_i,
  // Interrupt
  output logic                             irq_o
);

  localparam logic [`DIV_W-1:0]     DIV_LAST = `DIV_W'(`SERIAL_RESULT_CLOCK_HALF_CYC - 1);
  localparam logic [`BIT_CNT_W-1:0] BIT_LAST = `BIT_CNT_W'(`RESULT_BITS - 1);
  localparam logic [`CFG_CNT_W-1:0] CFG_LAST = `CFG_CNT_W'(`CFG_BITS - 1);

  adc_serial_pkg::ctrl_s        ctrl;
  adc_serial_pkg::irq_s         irq_status;
  adc_serial_pkg::irq_s         irq_mask;
  adc_serial_pkg::irq_s         irq_set;
  adc_serial_pkg::shift_state_e state;
  adc_serial_pkg::shift_state_e next_state;

  logic [4:0]                   sync_level;
  logic [4:0]                   sync_change;
  logic                         serial_result_clock_lvl_in;
  logic                         config_source_select_lvl;
  logic                         config_serial_in_lvl;
  logic                         config_serial_clock_lvl;
  logic                         config_port_select_lvl;
  logic                         serial_mode;
  logic                         slave_mode;
  logic                         active_lvl;
  logic                         slave_edge;
  logic                         slave_upd;
  logic                         master_load;
  logic                         bus_req;
  logic                         bus_do;
  logic                         ctrl_wr;
  logic [`RESULT_BITS-1:0]      coded;
  logic [`RESULT_BITS-1:0]      prev_result;
  logic [`RESULT_BITS-1:0]      shift_reg;
  logic [`RESULT_BITS-1:0]      next_shift;
  logic [`BIT_CNT_W-1:0]        bit_cnt;
  logic [`BIT_CNT_W-1:0]        next_bit_cnt;
  logic [`DIV_W-1:0]            div_cnt;
  logic [`DIV_W-1:0]            next_div_cnt;
  logic                         sclk_lvl;
  logic                         next_sclk_lvl;
  logic                         next_overrun;
  logic                         next_frame_done;
  logic [`CFG_BITS-1:0]         cfg_shift;
  logic [`CFG_BITS-1:0]         cfg_reg;
  logic [`CFG_CNT_W-1:0]        cfg_cnt;
  logic                         cfg_en;
  logic                         cfg_done;

  //////////////////////////////////////////////////////////////////////////////////////////////

  pin_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .async_i   ({config_port_select_i, config_serial_clock_i,
                 shared_pin_i.config_serial_in, shared_pin_i.config_source_select,
                 shared_pin_i.serial_result_clock}),
    .level_o   (sync_level),
    .change_o  (sync_change)
  );

  assign serial_result_clock_lvl_in = sync_level[0];
  assign config_source_select_lvl    = sync_level[1];
  assign config_serial_in_lvl     = sync_level[2];
  assign config_serial_clock_lvl    = sync_level[3];
  assign config_port_select_lvl     = sync_level[4];
  assign serial_mode  = ctrl.port_type_select;
  assign slave_mode   = ctrl.clock_source_select;
  // The updating edge is the one whose new level equals the inverse of the invert bit.
  assign active_lvl   = ~ctrl.clock_edge_invert;
  assign slave_edge   = serial_mode & slave_mode & sync_change[0];
  assign slave_upd    = slave_edge & (serial_result_clock_lvl_in == active_lvl);
  assign coded        = {conv_result_i[`RESULT_BITS-1] ^ ctrl.output_coding_select,
                         conv_result_i[`RESULT_BITS-2:0]};
  assign master_load  = serial_mode & ~slave_mode &
                        (ctrl.read_during_convert_select ? conv_start_i : conv_done_i);

  //////////////////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prev_result <= '0;
    end else if (conv_done_i) begin
      prev_result <= coded;
    end
  end

  always_comb begin
    next_state      = state;
    next_shift      = shift_reg;
    next_bit_cnt    = bit_cnt;
    next_div_cnt    = div_cnt;
    next_sclk_lvl   = sclk_lvl;
    next_overrun    = 1'b0;
    next_frame_done = 1'b0;
    case (state)
      adc_serial_pkg::SH_IDLE: begin
        next_sclk_lvl = active_lvl;
        next_div_cnt  = '0;
        if (master_load) begin
          next_shift   = ctrl.read_during_convert_select ? prev_result : coded;
          next_bit_cnt = '0;
          next_state   = adc_serial_pkg::SH_SHIFT;
        end else if (serial_mode && slave_mode && conv_done_i) begin
          next_shift   = coded;
          next_bit_cnt = '0;
          next_state   = adc_serial_pkg::SH_LOADED;
        end
      end
      adc_serial_pkg::SH_LOADED: begin
        if (conv_done_i) begin
          next_shift = coded;
        end else if (slave_edge) begin
          next_state = adc_serial_pkg::SH_SHIFT;
          if (slave_upd) begin
            next_shift   = {shift_reg[`RESULT_BITS-2:0], 1'b0};
            next_bit_cnt = bit_cnt + `BIT_CNT_W'(1);
          end
        end
      end
      adc_serial_pkg::SH_SHIFT: begin
        if (!slave_mode) begin
          if (div_cnt == DIV_LAST) begin
            next_div_cnt  = '0;
            next_sclk_lvl = ~sclk_lvl;
            if (~sclk_lvl == active_lvl) begin
              next_shift   = {shift_reg[`RESULT_BITS-2:0], 1'b0};
              next_bit_cnt = bit_cnt + `BIT_CNT_W'(1);
              if (bit_cnt == BIT_LAST) begin
                next_state      = adc_serial_pkg::SH_IDLE;
                next_frame_done = 1'b1;
              end
            end
          end else begin
            next_div_cnt = div_cnt + `DIV_W'(1);
          end
        end else begin
          if (slave_upd) begin
            next_shift   = {shift_reg[`RESULT_BITS-2:0], 1'b0};
            next_bit_cnt = bit_cnt + `BIT_CNT_W'(1);
          end
          if (slave_upd && bit_cnt == BIT_LAST) begin
            next_frame_done = 1'b1;
            next_state      = adc_serial_pkg::SH_IDLE;
            if (conv_done_i) begin
              next_shift   = coded;
              next_bit_cnt = '0;
              next_state   = adc_serial_pkg::SH_LOADED;
            end
          end else if (conv_done_i) begin
            next_overrun = 1'b1;
            next_shift   = coded;
            next_bit_cnt = '0;
            next_state   = adc_serial_pkg::SH_LOADED;
          end
        end
      end
      default: begin
        next_state = adc_serial_pkg::SH_IDLE;
      end
    endcase
    // Any change of mode abandons a frame rather than finishing it in a foreign mode.
    if (!serial_mode || ctrl_wr) begin
      next_state   = adc_serial_pkg::SH_IDLE;
      next_bit_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state     <= adc_serial_pkg::SH_IDLE;
      shift_reg <= '0;
      bit_cnt   <= '0;
      div_cnt   <= '0;
      sclk_lvl  <= 1'b1;
    end else begin
      state     <= next_state;
      shift_reg <= next_shift;
      bit_cnt   <= next_bit_cnt;
      div_cnt   <= next_div_cnt;
      sclk_lvl  <= next_sclk_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////

  // Pins are registered from the next values so clock, marker and data move together.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shared_pin_o        <= '0;
      shared_pin_oe_o     <= '0;
      serial_result_out_o <= 1'b0;
    end else if (!serial_mode) begin
      shared_pin_o        <= prev_result[13:9];
      shared_pin_oe_o     <= '1;
      serial_result_out_o <= 1'b0;
    end else begin
      serial_result_out_o                  <= next_shift[`RESULT_BITS-1];
      shared_pin_o.serial_result_clock     <= next_sclk_lvl;
      shared_pin_oe_o.serial_result_clock  <= ~slave_mode;
      shared_pin_o.frame_marker            <= ctrl.frame_polarity_select ^
                                              (next_state == adc_serial_pkg::SH_SHIFT);
      shared_pin_oe_o.frame_marker         <= ~slave_mode;
      shared_pin_o.read_overrun_flag       <= next_overrun;
      shared_pin_oe_o.read_overrun_flag    <= slave_mode;
      shared_pin_o.config_source_select    <= 1'b0;
      shared_pin_oe_o.config_source_select <= 1'b0;
      shared_pin_o.config_serial_in        <= 1'b0;
      shared_pin_oe_o.config_serial_in     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////

  assign cfg_en   = serial_mode & ~config_source_select_lvl & config_port_select_lvl;
  assign cfg_done = cfg_en & sync_change[3] & (config_serial_clock_lvl == active_lvl) & (cfg_cnt == CFG_LAST);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg_shift <= '0;
      cfg_cnt   <= '0;
      cfg_reg   <= `CFG_RESET;
    end else if (!cfg_en) begin
      cfg_cnt <= '0;
    end else if (sync_change[3] && config_serial_clock_lvl == active_lvl) begin
      cfg_shift <= {cfg_shift[`CFG_BITS-2:0], config_serial_in_lvl};
      if (cfg_done) begin
        cfg_reg <= {cfg_shift[`CFG_BITS-2:0], config_serial_in_lvl};
        cfg_cnt <= '0;
      end else begin
        cfg_cnt <= cfg_cnt + `CFG_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      active_settings_o <= '0;
    end else if (serial_mode && !config_source_select_lvl) begin
      active_settings_o <= cfg_reg;
    end else begin
      active_settings_o <= hw_settings_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////

  assign bus_req = avs_read_i | avs_write_i;
  assign bus_do  = bus_req & ~avs_waitrequest_o;
  assign ctrl_wr = bus_do & avs_write_i & avs_byteenable_i[0] & (avs_address_i == `REG_CTRL);
  assign irq_set = '{cfg_done: cfg_done, frame_done: next_frame_done, overrun: next_overrun};

  // Every access waits exactly one cycle; the read word is captured while waiting.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end else begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
      if (bus_req && avs_waitrequest_o && avs_read_i) begin
        case (avs_address_i)
          `REG_CTRL:       avs_readdata_o <= 32'(ctrl);
          `REG_STATUS:     avs_readdata_o <= 32'({cfg_cnt, config_source_select_lvl,
                                                  state == adc_serial_pkg::SH_LOADED,
                                                  state == adc_serial_pkg::SH_SHIFT});
          `REG_IRQ_STATUS: avs_readdata_o <= 32'(irq_status);
          `REG_IRQ_MASK:   avs_readdata_o <= 32'(irq_mask);
          `REG_CONFIG:     avs_readdata_o <= 32'(cfg_reg);
          default:         avs_readdata_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl     <= `CTRL_RESET;
      irq_mask <= `IRQ_RESET;
    end else if (bus_do && avs_write_i && avs_byteenable_i[0]) begin
      if (avs_address_i == `REG_CTRL) begin
        ctrl <= avs_writedata_i[5:0];
      end
      if (avs_address_i == `REG_IRQ_MASK) begin
        irq_mask <= avs_writedata_i[2:0];
      end
    end
  end

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_status <= `IRQ_RESET;
      irq_o      <= 1'b0;
    end else begin
      if (bus_do && avs_write_i && avs_byteenable_i[0] && avs_address_i == `REG_IRQ_STATUS) begin
        irq_status <= (irq_status & ~avs_writedata_i[2:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      irq_o <= |(irq_status & irq_mask);
    end
  end

endmodule

// [design/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  // Asynchronous inputs
  input  wire logic [WIDTH-1:0] async_i,
  // Filtered level and one-cycle change strobe
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] change_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] agree;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A new level only counts once the second and third stages agree.
  assign agree    = ~(stage2 ^ stage3);
  assign level_o  = (agree & stage3) | (~agree & held);
  assign change_o = level_o ^ held;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      held <= '0;
    end else begin
      held <= level_o;
    end
  end

endmodule

// [verification/adc_serial_port_and_config_select_bench.sv]
`timescale 1ns/100ps
`include "adc_serial_defs.svh"
module adc_serial_port_and_config_select_bench;
  logic sys_clk_i, srst_i, rd, wr, conv_start, conv_done, inv_r, pol_r, cfg_clk, cfg_sel;
  logic                         sout, waitreq, irq;
  logic [4:0]                   addr;
  logic [3:0]                   be;
  logic [31:0]                  wdata, rdata, d;
  logic [15:0]                  res, w;
  logic [7:0]                   hw_set, act_set;
  adc_serial_pkg::shared_pins_s pin_i, pin_o, pin_oe, host;
  adc_serial_pkg::ctrl_s        ctrl;
  int                           error_cnt = 0;
  int                           comparisons = 0;
  int                           k, n, b0;
  assign pin_i = adc_serial_pkg::shared_pins_s'((pin_oe & pin_o) | (~pin_oe & host));
  adc_serial_port DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .conv_start_i(conv_start),
    .conv_done_i(conv_done), .conv_result_i(res), .hw_settings_i(hw_set),
    .active_settings_o(act_set), .shared_pin_i(pin_i), .shared_pin_o(pin_o),
    .shared_pin_oe_o(pin_oe), .serial_result_out_o(sout),
    .config_serial_clock_i(cfg_clk), .config_port_select_i(cfg_sel), .irq_o(irq));
  host_model host_m (.sys_clk_i(sys_clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .sdata_i(sout),
    .inv_i(inv_r), .pol_i(pol_r), .host_o(host), .cfg_clk_o(cfg_clk), .cfg_sel_o(cfg_sel));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task bus(input logic we, input logic [4:0] a, input logic [31:0] dw, output logic [31:0] dr);
    int t;
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= dw;
    be <= 4'hF;
    rd <= ~we;
    wr <= we;
    t = 0;
    do begin
      @(posedge sys_clk_i);
      t++;
    end while (waitreq !== 1'b0 && t < 50);
    dr = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (t >= 50) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task pulse(input logic st, input logic [15:0] r);
    @(posedge sys_clk_i);
    conv_start <= st;
    conv_done <= ~st;
    res <= r;
    @(posedge sys_clk_i);
    conv_start <= 1'b0;
    conv_done <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    error_cnt++;
    stop_test();
  end
  initial begin
    {rd, wr, conv_start, conv_done, inv_r, pol_r} = 6'h00;
    {addr, be, wdata, res, hw_set} = 65'h0;
    srst_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    bus(0, `REG_CTRL, 0, d); check("ctrl reset", 32'h0, d);
    bus(1, 5'h14, 32'hFF, d); bus(0, 5'h14, 0, d); check("unmapped", 32'h0, d);
    pulse(0, 16'hA5C3); check("parallel pins", {27'h0, 5'b10010}, pin_o);
    check("parallel oe", 32'h1F, pin_oe);
    for (k = 0; k < 4; k++) begin
      ctrl = '{output_coding_select: k == 2, read_during_convert_select: k == 3,
        frame_polarity_select: k[1], clock_edge_invert: k[0], clock_source_select: 1'b0,
        port_type_select: 1'b1};
      inv_r <= k[0];
      pol_r <= k[1];
      bus(1, `REG_CTRL, {26'h0, ctrl}, d);
      w = 16'h9C31 ^ (16'h1357 * k[15:0]);
      b0 = host_m.bits;
      pulse(0, w);
      if (k == 3) pulse(1, 16'h0F0F);
      for (n = 0; n < 400 && host_m.bits < b0 + 16; n++) @(posedge sys_clk_i);
      // A frame that never completes is a failure, not a silent wait.
      if (n >= 400) begin
        error_cnt++;
        stop_test();
      end
      check("master word", {16'h0, w[15] ^ (k == 2), w[14:0]}, host_m.cap);
      repeat (4) @(posedge sys_clk_i);
      check("marker idle", {31'h0, k[1]}, pin_o.frame_marker);
    end
    check("irq masked", 32'h0, irq);
    bus(0, `REG_IRQ_STATUS, 0, d); check("frame done", 32'h2, d);
    bus(1, `REG_IRQ_MASK, 32'h7, d); bus(0, `REG_IRQ_MASK, 0, d); check("irq mask", 32'h7, d);
    check("irq on", 32'h1, irq);
    bus(1, `REG_IRQ_STATUS, 32'h2, d); bus(0, `REG_IRQ_STATUS, 0, d); check("w1c", 32'h0, d);
    check("irq off", 32'h0, irq);
    inv_r <= 1'b1;
    bus(1, `REG_CTRL, 32'h07, d);
    pulse(0, 16'h3C5A); host_m.slave_read(16, w); check("slave word", 32'h3C5A, w);
    inv_r <= 1'b0;
    bus(1, `REG_CTRL, 32'h03, d);
    bus(1, `REG_IRQ_STATUS, 32'h7, d);
    pulse(0, 16'h1234); host_m.slave_read(5, w); pulse(0, 16'hBEEF);
    check("overrun pulses", 32'h1, host_m.ovr);
    bus(0, `REG_IRQ_STATUS, 0, d); check("overrun irq", 32'h1, d & 32'h1);
    host_m.slave_read(16, w); check("after overrun", 32'hBEEF, w);
    hw_set <= 8'h3A;
    host_m.cfg_write(8'hC5); repeat (6) @(posedge sys_clk_i);
    bus(0, `REG_CONFIG, 0, d); check("config word", 32'hC5, d);
    check("soft settings", 32'hC5, act_set);
    host_m.set_src(1'b1); repeat (6) @(posedge sys_clk_i);
    check("hard settings", 32'h3A, act_set);
    host_m.cfg_write(8'h0F); bus(0, `REG_CONFIG, 0, d); check("config held", 32'hC5, d);
    stop_test();
  end
endmodule

// [verification/adc_serial_port_assertions.sv]
`timescale 1ns/100ps
module adc_serial_port_assertions (
  // Clock and reset
  input wire logic                         sys_clk_i,
  input wire logic                         srst_i,
  // Observed ports
  input wire logic                         avs_read_i,
  input wire logic                         avs_write_i,
  input wire logic                         avs_waitrequest_o,
  input wire logic                         conv_done_i,
  input wire adc_serial_pkg::shared_pins_s shared_pin_o,
  input wire adc_serial_pkg::shared_pins_s shared_pin_oe_o,
  input wire logic                         serial_result_out_o
);
  logic       mst;
  logic [5:0] tg;
  assign mst = shared_pin_oe_o.frame_marker && !shared_pin_oe_o.config_serial_in;
  // A control write may move the idle clock once, so an idle span may show one toggle.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !mst || $changed(shared_pin_o.frame_marker)) tg <= 6'h00;
    else if ($changed(shared_pin_o.serial_result_clock)) tg <= tg + 6'h01;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_wait_one_cycle: assert property ($rose(avs_read_i || avs_write_i) |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("wait state count wrong");
  // In parallel mode the overrun pin carries a data bit, so only serial mode is watched.
  a_overrun_has_cause: assert property (
    !shared_pin_oe_o.config_serial_in && shared_pin_oe_o.read_overrun_flag &&
    shared_pin_o.read_overrun_flag |-> $past(conv_done_i))
    else $error("overrun without conversion end");
  a_overrun_one_cycle: assert property (
    !shared_pin_oe_o.config_serial_in && shared_pin_oe_o.read_overrun_flag &&
    shared_pin_o.read_overrun_flag |=> !shared_pin_o.read_overrun_flag)
    else $error("overrun pulse too long");
  a_marker_with_clock: assert property (
    shared_pin_oe_o.frame_marker == shared_pin_oe_o.serial_result_clock)
    else $error("marker driven outside master mode");
  // The pins still show their reset state one edge after release.
  a_overrun_slave_only: assert property (!$past(srst_i) &&
    !shared_pin_oe_o.config_serial_in |->
    shared_pin_oe_o.read_overrun_flag != shared_pin_oe_o.serial_result_clock)
    else $error("clock and overrun drive clash");
  a_parallel_pins: assert property (shared_pin_oe_o.config_serial_in |->
    shared_pin_oe_o == 5'h1F && serial_result_out_o == 1'b0) else $error("parallel pins wrong");
  a_inputs_released: assert property (
    shared_pin_oe_o.config_source_select == shared_pin_oe_o.config_serial_in)
    else $error("config inputs driven in serial mode");
  a_master_update_edge: assert property (mst && $stable(shared_pin_oe_o) &&
    $stable(shared_pin_o.frame_marker) && $changed(serial_result_out_o)
    |-> $changed(shared_pin_o.serial_result_clock)) else $error("data moved without clock");
  a_marker_frame_len: assert property (mst && $stable(shared_pin_oe_o) &&
    $changed(shared_pin_o.frame_marker) |-> (tg < 6'h02) ||
    (tg == 6'h1F && $changed(shared_pin_o.serial_result_clock)))
    else $error("marker span not sixteen bits");
endmodule

bind adc_serial_port adc_serial_port_assertions u_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .conv_done_i(conv_done_i), .shared_pin_o(shared_pin_o),
  .shared_pin_oe_o(shared_pin_oe_o), .serial_result_out_o(serial_result_out_o));

// [verification/host_model.sv]
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic                         sys_clk_i,
  // Device side
  input  wire adc_serial_pkg::shared_pins_s pin_o_i,
  input  wire adc_serial_pkg::shared_pins_s pin_oe_i,
  input  wire logic                         sdata_i,
  input  wire logic                         inv_i,
  input  wire logic                         pol_i,
  // Host drive
  output adc_serial_pkg::shared_pins_s      host_o,
  output logic                              cfg_clk_o,
  output logic                              cfg_sel_o
);
  logic        clk = 1'b0;
  logic        src = 1'b0;
  logic        din = 1'b0;
  logic        noise = 1'b0;
  logic        prev_clk = 1'b0;
  logic [15:0] cap = 16'h0000;
  int          bits = 0;
  int          ovr = 0;
  initial cfg_clk_o = 1'b0;
  initial cfg_sel_o = 1'b0;
  // Undriven marker and overrun lines see a changing level, never a held one.
  assign host_o = {din, src, noise, ~noise, clk};
  always @(posedge sys_clk_i) begin
    noise <= ~noise;
    prev_clk <= pin_o_i.serial_result_clock;
    if (pin_oe_i.frame_marker && !pin_oe_i.config_serial_in &&
        pin_o_i.serial_result_clock != prev_clk && pin_o_i.serial_result_clock == inv_i &&
        pin_o_i.frame_marker == ~pol_i) begin
      cap <= {cap[14:0], sdata_i};
      bits <= bits + 1;
    end
    if (pin_oe_i.read_overrun_flag && pin_o_i.read_overrun_flag) ovr <= ovr + 1;
  end
  task slave_read(input int n, output logic [15:0] w);
    int i;
    w = 16'h0000;
    @(posedge sys_clk_i) clk <= inv_i;
    repeat (8) @(posedge sys_clk_i);
    for (i = 0; i < n; i++) begin
      w = {w[14:0], sdata_i};
      clk <= ~inv_i;
      repeat (4) @(posedge sys_clk_i);
      clk <= inv_i;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
  task cfg_write(input logic [7:0] b);
    int i;
    @(posedge sys_clk_i) cfg_sel_o <= 1'b1;
    cfg_clk_o <= inv_i;
    for (i = 7; i >= 0; i--) begin
      repeat (4) @(posedge sys_clk_i);
      din <= b[i];
      repeat (4) @(posedge sys_clk_i);
      cfg_clk_o <= ~inv_i;
      repeat (4) @(posedge sys_clk_i);
      cfg_clk_o <= inv_i;
    end
    repeat (4) @(posedge sys_clk_i);
    cfg_sel_o <= 1'b0;
    din <= ~din;
  endtask
  task set_src(input logic v);
    @(posedge sys_clk_i) src <= v;
  endtask
endmodule
